// *** verilog/atp_pkg.sv ***
// Package for the PIO host cycle engine: timing figures, cycle counts, types.
// Assumes a single 40 MHz clock; all counts are derived from ns figures.
package atp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CW = 8;  // Width of phase counters

  // Round up for minimums, down for maximums, never below one cycle
  function automatic logic [CW-1:0] atp_ceil(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return c[CW-1:0];
  endfunction
  function automatic logic [CW-1:0] atp_floor(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return c[CW-1:0];
  endfunction

  // Per-mode figures in ns, modes 0..6
  localparam int unsigned T_CYCLE_NS [7] = '{600, 383, 240, 180, 120, 100, 80};
  localparam int unsigned T_ACT16_NS [7] = '{165, 125, 100, 80, 70, 65, 55};
  localparam int unsigned T_ACT8_NS  [7] = '{290, 290, 290, 80, 70, 65, 55};
  localparam int unsigned T_REC_NS   [7] = '{0, 0, 0, 70, 25, 25, 20};
  localparam int unsigned T_SETUP_NS [7] = '{70, 50, 30, 30, 25, 15, 10};
  localparam int unsigned T_HOLD_NS  [7] = '{20, 15, 10, 10, 10, 10, 10};
  localparam int unsigned T_W16_NS   [7] = '{90, 50, 40, 0, 0, 0, 0};
  localparam int unsigned T_TRI_NS   [7] = '{30, 30, 30, 30, 30, 20, 20};
  localparam int unsigned T_RDY_SAMPLE_NS = 35;
  localparam int unsigned T_RDY_MAX_NS    = 1250;
  localparam logic [2:0]  MODE_MAX        = 3'h6;
  localparam logic [2:0]  MODE_NO_WAIT    = 3'h5;
  localparam logic [2:0]  MODE_W16_LAST   = 3'h2;

  // Host request word
  typedef struct packed {
    logic        write;
    logic        wide;      // 16-bit data access
    logic [1:0]  sel;       // Block select, one-hot active high
    logic [2:0]  addr;
    logic [15:0] wdata;
  } atp_req_t;

  // Completion word
  typedef struct packed {
    logic        write;
    logic        timeout;   // Ready held low past its longest stretch
    logic        is16;      // Width indicator seen (modes 0..2 only)
    logic [15:0] rdata;
  } atp_rsp_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACT   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_HOLD  = 3'b100,
    ST_REC   = 3'b101
  } atp_state_t;
endpackage

// *** verilog/atp_skid.sv ***
// Two-entry buffer with valid/ready on both sides.
// Assumes the consumer may stall indefinitely; nothing is dropped.
module atp_skid
  import atp_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_b,
  input  wire atp_rsp_t in_data,
  input  wire logic     in_valid,
  output logic          in_ready,
  output atp_rsp_t      out_data,
  output logic          out_valid,
  input  wire logic     out_ready
);
  atp_rsp_t   mem_r [2];
  logic       wp_r;
  logic       rp_r;
  logic [1:0] cnt_r;
  logic       push;
  logic       pop;

  // Honest full/empty from the occupancy count
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage writes
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// *** verilog/atp_host.sv ***
// PIO host cycle engine: turns requests into timed strobe cycles on the port.
// Assumes device pins are synchronous to mclk; data bus is split in/out/oe.
module atp_host
  import atp_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst_b,
  input  wire logic [2:0] pio_mode,
  input  wire atp_req_t req_data,
  input  wire logic     req_valid,
  output logic          req_ready,
  output atp_rsp_t      rsp_data,
  output logic          rsp_valid,
  input  wire logic     rsp_ready,
  output logic          host_read_strobe_n,
  output logic          host_write_strobe_n,
  output logic          select_block0_n,
  output logic          select_block1_n,
  output logic [2:0]    reg_addr,
  input  wire logic [15:0] host_data_bus_in,
  output logic [15:0]   host_data_bus_out,
  output logic          host_data_bus_oe,
  input  wire logic     cycle_ready,
  input  wire logic     width16_indicator_n
);
  atp_state_t state_r;
  atp_req_t   cur_r;
  logic [2:0] mode_r;
  logic [CW-1:0] ph_cnt_r;    // Cycles spent in current phase
  logic [CW-1:0] cyc_cnt_r;   // Cycles since strobe start
  logic [CW-1:0] wait_cnt_r;  // Cycles ready held low
  logic       timeout_r;
  logic       is16_r;
  logic [15:0] rdata_r;
  logic       fifo_valid_r;
  logic       fifo_in_ready;
  atp_rsp_t   fifo_out;
  logic       fifo_out_valid;
  logic       req_ready_r;
  logic       rsp_valid_r;
  atp_rsp_t   rsp_r;
  atp_rsp_t   fifo_in;
  logic [CW-1:0] n_setup, n_act, n_rec, n_cycle, n_hold, n_tri, n_w16;
  logic [CW-1:0] n_sample, n_rdy_max;
  logic       use_ready;
  logic       act_done;

  // Per-mode cycle counts, looked up from the latched mode
  always_comb begin
    n_setup   = atp_ceil(T_SETUP_NS[mode_r]);
    n_act     = cur_r.wide ? atp_ceil(T_ACT16_NS[mode_r])
                           : atp_ceil(T_ACT8_NS[mode_r]);
    n_rec     = atp_ceil(T_REC_NS[mode_r]);
    n_cycle   = atp_ceil(T_CYCLE_NS[mode_r]);
    n_hold    = atp_ceil(T_HOLD_NS[mode_r]);
    n_tri     = atp_ceil(T_TRI_NS[mode_r]);
    n_w16     = atp_floor(T_W16_NS[mode_r]);
    n_sample  = atp_ceil(T_RDY_SAMPLE_NS);
    n_rdy_max = atp_floor(T_RDY_MAX_NS);
    use_ready = (mode_r < MODE_NO_WAIT);
    act_done  = (ph_cnt_r >= n_act - 8'h01) && (ph_cnt_r >= n_sample);
  end

  // Phase sequencer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_r   <= ST_IDLE;
      cur_r     <= '0;
      mode_r    <= 3'h0;
      ph_cnt_r  <= '0;
      cyc_cnt_r <= '0;
      wait_cnt_r <= '0;
    end else begin
      ph_cnt_r  <= ph_cnt_r + 8'h01;
      if (cyc_cnt_r != 8'hff) cyc_cnt_r <= cyc_cnt_r + 8'h01;
      case (state_r)
        ST_IDLE: begin
          if (req_valid && req_ready_r) begin
            cur_r    <= req_data;
            mode_r   <= (pio_mode > MODE_MAX) ? MODE_MAX : pio_mode;
            ph_cnt_r <= '0;
            state_r  <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (ph_cnt_r >= n_setup - 8'h01) begin
            ph_cnt_r   <= '0;
            cyc_cnt_r  <= '0;
            wait_cnt_r <= '0;
            state_r    <= ST_ACT;
          end
        end
        ST_ACT: begin
          // Ready is looked at only at the sample point, so a dip that
          // recovers before it inserts no wait
          if (act_done) begin
            if (use_ready && !cycle_ready) begin
              state_r <= ST_WAIT;
            end else begin
              ph_cnt_r <= '0;
              state_r  <= ST_HOLD;
            end
          end
        end
        ST_WAIT: begin
          wait_cnt_r <= wait_cnt_r + 8'h01;
          if (cycle_ready || wait_cnt_r >= n_rdy_max) begin
            ph_cnt_r <= '0;
            state_r  <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Address hold after strobe end; reads also wait out bus release
          if (ph_cnt_r >= n_hold - 8'h01 &&
              (cur_r.write || ph_cnt_r >= n_tri - 8'h01)) begin
            ph_cnt_r <= '0;
            state_r  <= ST_REC;
          end
        end
        ST_REC: begin
          if (ph_cnt_r >= n_rec - 8'h01 &&
              cyc_cnt_r >= n_cycle - 8'h01 - n_setup &&
              fifo_in_ready) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Strobes, selects and address straight from flops
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      host_read_strobe_n  <= 1'b1;
      host_write_strobe_n <= 1'b1;
      select_block0_n     <= 1'b1;
      select_block1_n     <= 1'b1;
      reg_addr            <= 3'h0;
      host_data_bus_out   <= 16'h0000;
      host_data_bus_oe    <= 1'b0;
    end else begin
      host_read_strobe_n  <= !(((state_r == ST_SETUP) &&
                             (ph_cnt_r >= n_setup - 8'h01) && !cur_r.write) ||
                             (((state_r == ST_ACT) && !act_done) ||
                              ((state_r == ST_ACT) && use_ready &&
                               !cycle_ready) ||
                              ((state_r == ST_WAIT) && !cycle_ready &&
                               wait_cnt_r < n_rdy_max)) && !cur_r.write);
      host_write_strobe_n <= !(((state_r == ST_SETUP) &&
                             (ph_cnt_r >= n_setup - 8'h01) && cur_r.write) ||
                             (((state_r == ST_ACT) && !act_done) ||
                              ((state_r == ST_ACT) && use_ready &&
                               !cycle_ready) ||
                              ((state_r == ST_WAIT) && !cycle_ready &&
                               wait_cnt_r < n_rdy_max)) && cur_r.write);
      if (state_r == ST_IDLE && req_valid && req_ready_r) begin
        select_block0_n   <= !req_data.sel[0];
        select_block1_n   <= !req_data.sel[1];
        reg_addr          <= req_data.addr;
        host_data_bus_out <= req_data.wide ? req_data.wdata
                             : {8'h00, req_data.wdata[7:0]};
        host_data_bus_oe  <= req_data.write;
      end else if (state_r == ST_REC) begin
        select_block0_n  <= 1'b1;
        select_block1_n  <= 1'b1;
        host_data_bus_oe <= 1'b0;
      end
    end
  end

  // Capture of read data, width indicator and timeout
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata_r   <= 16'h0000;
      is16_r    <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      if (state_r == ST_SETUP) begin
        timeout_r <= 1'b0;
        is16_r    <= 1'b0;
      end
      if (state_r == ST_ACT && ph_cnt_r == 8'h00 &&
          mode_r <= MODE_W16_LAST && n_setup + 8'h01 > n_w16) begin
        is16_r <= !width16_indicator_n;
      end
      if ((state_r == ST_ACT && act_done && !(use_ready && !cycle_ready)) ||
          (state_r == ST_WAIT && cycle_ready)) begin
        rdata_r <= cur_r.wide ? host_data_bus_in
                   : {8'h00, host_data_bus_in[7:0]};
      end
      if (state_r == ST_WAIT && !cycle_ready && wait_cnt_r >= n_rdy_max) begin
        timeout_r <= 1'b1;
      end
    end
  end

  // Completion push into the buffer at end of recovery
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fifo_valid_r <= 1'b0;
    end else begin
      fifo_valid_r <= (state_r == ST_REC) && (ph_cnt_r >= n_rec - 8'h01) &&
                      (cyc_cnt_r >= n_cycle - 8'h01 - n_setup) &&
                      fifo_in_ready;
    end
  end

  // Completion word as it enters the buffer; held until the next take
  assign fifo_in = '{write: cur_r.write, timeout: timeout_r,
                     is16: is16_r, rdata: rdata_r};

  atp_skid u_skid (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_data   (fifo_in),
    .in_valid  (fifo_valid_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (!rsp_valid_r || rsp_ready)
  );

  // Registered request and response handshakes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      req_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      req_ready_r <= (state_r == ST_IDLE) && !(req_valid && req_ready_r) &&
                     !fifo_valid_r;
      if (!rsp_valid_r || rsp_ready) begin
        rsp_valid_r <= fifo_out_valid;
        rsp_r       <= fifo_out;
      end
    end
  end

  assign req_ready = req_ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data  = rsp_r;
endmodule

// *** verification/atp_host_sva.sv ***
// Checker for the PIO host engine: strobe timing, waits, pin stability.
// Assumes it is bound onto atp_host; one clock, synchronous reset.
module atp_host_sva
  import atp_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [2:0] pio_mode,
  input wire atp_req_t   req_data,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire atp_rsp_t   rsp_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic       host_read_strobe_n,
  input wire logic       host_write_strobe_n,
  input wire logic       select_block0_n,
  input wire logic       select_block1_n,
  input wire logic [2:0] reg_addr,
  input wire logic       host_data_bus_oe,
  input wire logic       cycle_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Mode minimums in 25 ns cycles, rounded up
  localparam int CYC [7] = '{24, 16, 10, 8, 5, 4, 4};
  localparam int ACT [7] = '{7, 5, 4, 4, 3, 3, 3};
  localparam int REC [7] = '{1, 1, 1, 3, 1, 1, 1};
  logic       lo;
  logic       lo_r;
  logic       seen_r;
  logic       wide_r;
  logic [2:0] md_r;
  logic [2:0] pmd_r;
  logic [7:0] act_r;
  logic [7:0] ina_r;
  logic [7:0] cyc_r;
  assign lo = !host_read_strobe_n || !host_write_strobe_n;
  // Mode of the cycle in flight; taken only while idle, so never mid-strobe
  always_ff @(posedge mclk) begin
    if (req_valid && req_ready) begin
      md_r   <= (pio_mode > 3'h6) ? 3'h6 : pio_mode;
      wide_r <= req_data.wide;
    end
  end
  // Saturating phase counters; the previous mode judges the gap before a fall
  always_ff @(posedge mclk) begin
    lo_r  <= lo;
    act_r <= lo ? act_r + 8'(act_r != 8'hff) : 8'h00;
    ina_r <= lo ? 8'h00 : ina_r + 8'(ina_r != 8'hff);
    cyc_r <= (lo && !lo_r) ? 8'h01 : cyc_r + 8'(cyc_r != 8'hff);
    if (lo && !lo_r) begin
      seen_r <= 1'b1;
      pmd_r  <= md_r;
    end
    if (!rst_b) begin
      seen_r <= 1'b0;
      ina_r  <= 8'hff;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_cycle_min: assert property (
    lo && !lo_r && seen_r |-> cyc_r >= CYC[pmd_r]
  ) else $error("strobe cycle shorter than the mode minimum");
  a_active_min: assert property (
    !lo && lo_r |-> act_r >= ((!wide_r && md_r < 3'h3) ? 12 : ACT[md_r])
  ) else $error("strobe active time too short");
  a_recovery_min: assert property (
    lo && !lo_r && seen_r |-> ina_r >= REC[pmd_r]
  ) else $error("strobe recovery too short");
  a_wait_ready: assert property (
    !lo && lo_r && md_r < 3'h5 && act_r < 8'h32 |-> $past(cycle_ready)
  ) else $error("strobe ended while ready was low");
  a_wait_cap: assert property (
    lo |-> act_r < 8'h40
  ) else $error("host waited past the ready limit");
  a_fast_nowait: assert property (
    lo && md_r > 3'h4 |-> act_r < 8'h08
  ) else $error("fast mode cycle was stretched");
  a_read_release: assert property (
    !host_read_strobe_n |-> !host_data_bus_oe
  ) else $error("host drove the bus during a read");
  a_one_select: assert property (
    lo |-> select_block0_n ^ select_block1_n
  ) else $error("not exactly one block selected");
  a_addr_stable: assert property (
    lo && lo_r |-> $stable({select_block0_n, select_block1_n, reg_addr})
  ) else $error("address moved under an active strobe");
  c_wait: cover property (lo && !cycle_ready && md_r < 3'h5);
  c_timeout: cover property (rsp_valid && rsp_data.timeout);
  c_stall: cover property (rsp_valid && !rsp_ready ##1 !req_ready);
endmodule

bind atp_host atp_host_sva u_atp_host_sva (
  .mclk(mclk), .rst_b(rst_b), .pio_mode(pio_mode), .req_data(req_data),
  .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
  .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
  .host_read_strobe_n(host_read_strobe_n),
  .host_write_strobe_n(host_write_strobe_n),
  .select_block0_n(select_block0_n), .select_block1_n(select_block1_n),
  .reg_addr(reg_addr), .host_data_bus_oe(host_data_bus_oe),
  .cycle_ready(cycle_ready)
);

// *** verification/atp_dev_model.sv ***
// Device model: register array, ready stretching, width indicator.
// Assumes host pins change on mclk; the bench sets the stretch per request.
module atp_dev_model
  import atp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        take,
  input  wire logic [7:0]  wait_len,
  input  wire logic        host_read_strobe_n,
  input  wire logic        host_write_strobe_n,
  input  wire logic        select_block0_n,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] host_data_bus_out,
  input  wire logic        host_data_bus_oe,
  output logic [15:0]      host_data_bus_in,
  output logic             cycle_ready,
  output logic             width16_indicator_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [15:0] last_r;
  logic [7:0]  wl_r;
  logic [7:0]  cnt_r;
  logic        lo_r;
  logic        lo;
  assign lo = !host_read_strobe_n || !host_write_strobe_n;
  // Read data valid from strobe start, so always before ready; no pull-up,
  // so a released bus toggles every cycle instead of keeping its value
  assign host_data_bus_in = !host_read_strobe_n ?
    mem[{select_block0_n, reg_addr}] :
    (host_data_bus_oe ? host_data_bus_out : ~last_r);
  // Only block 0 address 0 is the 16-bit data register
  assign width16_indicator_n = select_block0_n || reg_addr != 3'h0;
  // Stretch length latched at take, since the bench queues the next early
  always_ff @(posedge mclk) begin
    lo_r   <= lo;
    last_r <= host_data_bus_in;
    if (take)
      wl_r <= wait_len;
    if (!host_write_strobe_n)
      mem[{select_block0_n, reg_addr}] <= host_data_bus_out;
    if (lo && !lo_r && wl_r != 8'h00) begin
      cycle_ready <= 1'b0;
      cnt_r       <= wl_r;
    end else if (cnt_r > 8'h01) begin
      cnt_r <= cnt_r - 8'h01;
    end else begin
      cycle_ready <= 1'b1;
    end
  end
endmodule

// *** verification/test_atp_host.sv ***
// Bench for the PIO host engine with device model and response scoreboard.
// Assumes the design, model and checker files are compiled before it.
module test_atp_host
  import atp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_b, req_valid, req_ready, rsp_valid, rsp_ready;
  logic        rd_n, wr_n, s0_n, rdy, w16_n, oe, stall;
  logic [2:0]  pio_mode, reg_addr;
  logic [7:0]  wait_len;
  logic [15:0] bus_in, bus_out;
  logic [15:0] mirror [16];
  atp_req_t    req_data;
  atp_rsp_t    rsp_data;
  atp_rsp_t    exp_q [$];
  int          num_errors, compares;
  atp_host u_atp_host (
    .mclk(mclk), .rst_b(rst_b), .pio_mode(pio_mode), .req_data(req_data),
    .req_valid(req_valid), .req_ready(req_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
    .select_block0_n(s0_n), .select_block1_n(), .reg_addr(reg_addr),
    .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
    .host_data_bus_oe(oe), .cycle_ready(rdy), .width16_indicator_n(w16_n));
  atp_dev_model u_atp_dev_model (
    .mclk(mclk), .take(req_valid && req_ready), .wait_len(wait_len),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
    .select_block0_n(s0_n), .reg_addr(reg_addr),
    .host_data_bus_out(bus_out), .host_data_bus_oe(oe),
    .host_data_bus_in(bus_in), .cycle_ready(rdy),
    .width16_indicator_n(w16_n));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One request; the expected response is noted before it is offered
  task automatic access(input logic wr, input logic blk, input logic [2:0] a,
                        input logic [2:0] m, input logic [7:0] wl);
    atp_req_t r;
    atp_rsp_t e;
    logic     wide;
    int       n;
    wide = !blk && a == 3'h0;
    r = '{wr, wide, blk ? 2'b10 : 2'b01, a, 16'($urandom)};
    e = '{wr, wl > 8'h32 && m < 3'h5, wide && m < 3'h3,
          wide ? mirror[{blk, a}] : {8'h00, mirror[{blk, a}][7:0]}};
    if (wr)
      mirror[{blk, a}] = r.wdata;
    exp_q.push_back(e);
    @(posedge mclk);
    pio_mode  <= m;
    wait_len  <= wl;
    req_data  <= r;
    req_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!req_ready && n < 3000);
    req_valid <= 1'b0;
    if (n >= 3000) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // Scoreboard: oldest note against each response handed over
  always @(posedge mclk) begin
    if (rst_b && rsp_valid && rsp_ready) begin
      atp_rsp_t e;
      e = exp_q.pop_front();
      chk("write", 16'(rsp_data.write), 16'(e.write));
      chk("timeout", 16'(rsp_data.timeout), 16'(e.timeout));
      chk("is16", 16'(rsp_data.is16), 16'(e.is16));
      if (!e.write) chk("rdata", rsp_data.rdata, e.rdata);
    end
  end
  // Random consumer stalls; a long forced stall fills the buffer
  always @(posedge mclk) rsp_ready <= !stall && ($urandom % 4 != 0);
  initial begin
    logic       blk;
    logic [2:0] a;
    void'($urandom(91908));
    rst_b     = 1'b0;
    req_valid = 1'b0;
    req_data  = '0;
    pio_mode  = 3'h0;
    wait_len  = 8'h00;
    stall     = 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    // Every mode, 7 clamping to 6: wide and byte write/read, random stretch
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) begin
        if (!k[0]) begin
          blk = k[1] & 1'($urandom);
          a   = k[1] ? 3'($urandom_range(1, 7)) : 3'h0;
        end
        access(!k[0], blk, a, 3'(m), 8'($urandom_range(0, 20)));
      end
    end
    // Ready held low past the limit even after a 12-cycle byte strobe,
    // yet back high before the read that follows starts its strobe
    access(1'b1, 1'b0, 3'h3, 3'h0, 8'h40);
    access(1'b0, 1'b0, 3'h3, 3'h0, 8'h00);
    stall <= 1'b1;
    fork
      begin
        repeat (400) @(posedge mclk);
        stall <= 1'b0;
      end
    join_none
    for (int k = 0; k < 6; k++) access(!k[0], 1'b1, 3'h5, 3'h4, 8'h00);
    for (int n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge mclk);
    if (exp_q.size() != 0)
      num_errors++;
    report_and_stop();
  end
endmodule
